// file: rtl/spf_device.sv
// Device end: receives and checks packets, answers probes, frames replies.
// Assumes the line is synchronous to mclk_i and the user answers commands.
`timescale 1ns/1ps
`default_nettype none
`include "spf_defines.svh"
module spf_device #(
  parameter int LIMIT_CYC = `SPF_LIMIT_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire spf_pkg::spf_baud_t baud_sel_i,
  // Serial line
  spf_link_if.device link,
  // Accepted command
  output logic cmd_valid_o,
  output logic [15:0] cmd_type_o,
  output logic [7:0] cmd_len_o,
  output var spf_pkg::spf_class_t cmd_class_o,
  output logic discard_o,
  input wire logic [7:0] pay_addr_i,
  output logic [7:0] pay_data_o,
  // Reply request
  input wire logic rsp_wr_i,
  input wire logic [7:0] rsp_wr_addr_i,
  input wire logic [7:0] rsp_wr_data_i,
  input wire logic rsp_send_i,
  input wire logic rsp_nak_i,
  input wire logic [15:0] rsp_type_i,
  input wire logic [7:0] rsp_len_i,
  output logic rsp_busy_o
);
  import spf_pkg::*;

  logic [11:0] bit_len;
  assign bit_len = spf_bit_cycles(baud_sel_i);

  // Receiver: 8N1 sampled mid-bit
  logic rxd_q;
  logic rx_busy;
  logic [11:0] rx_cnt;
  logic [3:0] rx_idx;
  logic [7:0] rx_sh;
  logic rx_stb;
  logic [7:0] rx_byte;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rxd_q <= 1'b1;
      rx_busy <= 1'b0;
      rx_cnt <= 12'h000;
      rx_idx <= 4'h0;
      rx_sh <= 8'h00;
      rx_stb <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      rx_stb <= 1'b0;
      rxd_q <= link.host_txd;
      if (!rx_busy) begin
        if (rxd_q && !link.host_txd) begin
          rx_busy <= 1'b1;
          rx_cnt <= bit_len >> 1;
          rx_idx <= 4'h0;
        end
      end else if (rx_cnt != 12'h000) begin
        rx_cnt <= rx_cnt - 12'h001;
      end else begin
        rx_cnt <= bit_len - 12'h001;
        rx_idx <= rx_idx + 4'h1;
        if (rx_idx == 4'h0) begin
          if (link.host_txd) rx_busy <= 1'b0;
        end else if (rx_idx < 4'h9) begin
          rx_sh <= {link.host_txd, rx_sh[7:1]};
        end else begin
          rx_busy <= 1'b0;
          if (link.host_txd) begin
            rx_stb <= 1'b1;
            rx_byte <= rx_sh;
          end
        end
      end
    end
  end

  // Packet parser
  spf_rx_st_t rs;
  logic [15:0] ty;
  logic [7:0] len;
  logic [7:0] idx;
  logic [15:0] crc;
  logic [7:0] crc_hi;
  logic [31:0] tmo;
  logic [31:0] gap;
  logic probe_set;
  logic ping_set;
  logic [7:0] rx_mem [256];
  logic [31:0] gap_cyc;
  assign gap_cyc = 32'(bit_len) * `SPF_PROBE_GAP_BITS;

  always_ff @(posedge mclk_i) begin
    if (rst_i || rs == SPF_R_HDR1) tmo <= 32'h0000_0000;
    else tmo <= tmo + 32'h0000_0001;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || rx_stb) gap <= 32'h0000_0000;
    else if (gap < gap_cyc) gap <= gap + 32'h0000_0001;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rs <= SPF_R_HDR1;
      ty <= 16'h0000;
      len <= 8'h00;
      idx <= 8'h00;
      crc <= `SPF_CRC_INIT;
      crc_hi <= 8'h00;
      probe_set <= 1'b0;
      ping_set <= 1'b0;
      discard_o <= 1'b0;
      cmd_valid_o <= 1'b0;
      cmd_type_o <= 16'h0000;
      cmd_len_o <= 8'h00;
      cmd_class_o <= SPF_CL_OTHER;
    end else begin
      cmd_valid_o <= 1'b0;
      discard_o <= 1'b0;
      probe_set <= 1'b0;
      ping_set <= 1'b0;
      if (rs != SPF_R_HDR1 && tmo >= 32'(LIMIT_CYC - 1)) begin
        rs <= SPF_R_HDR1;
      end else if (rs == SPF_R_LEN && ty == `SPF_T_PING && gap >= gap_cyc) begin
        probe_set <= 1'b1;
        rs <= SPF_R_HDR1;
      end else if (rx_stb) begin
        case (rs)
          SPF_R_HDR1: if (rx_byte == `SPF_PRE) rs <= SPF_R_HDR2;
          SPF_R_HDR2: begin
            rs <= (rx_byte == `SPF_PRE) ? SPF_R_TYH : SPF_R_HDR1;
            crc <= `SPF_CRC_INIT;
          end
          SPF_R_TYH: begin
            ty[15:8] <= rx_byte;
            crc <= spf_crc_upd(crc, rx_byte);
            rs <= SPF_R_TYL;
          end
          SPF_R_TYL: begin
            ty[7:0] <= rx_byte;
            crc <= spf_crc_upd(crc, rx_byte);
            rs <= SPF_R_LEN;
          end
          SPF_R_LEN: begin
            len <= rx_byte;
            idx <= 8'h00;
            crc <= spf_crc_upd(crc, rx_byte);
            rs <= (rx_byte == 8'h00) ? SPF_R_CRCH : SPF_R_PAY;
          end
          SPF_R_PAY: begin
            crc <= spf_crc_upd(crc, rx_byte);
            idx <= idx + 8'h01;
            if (idx == len - 8'h01) rs <= SPF_R_CRCH;
          end
          SPF_R_CRCH: begin
            crc_hi <= rx_byte;
            rs <= SPF_R_CRCL;
          end
          SPF_R_CRCL: begin
            rs <= SPF_R_HDR1;
            if ({crc_hi, rx_byte} != crc) begin
              discard_o <= 1'b1;
            end else if (ty == `SPF_T_PING && len == 8'h00) begin
              ping_set <= 1'b1;
            end else begin
              cmd_valid_o <= 1'b1;
              cmd_type_o <= ty;
              cmd_len_o <= len;
              cmd_class_o <= spf_class_of(ty);
            end
          end
          default: rs <= SPF_R_HDR1;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rx_stb && rs == SPF_R_PAY) rx_mem[idx] <= rx_byte;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) pay_data_o <= 8'h00;
    else pay_data_o <= rx_mem[pay_addr_i];
  end

  // Transmit side
  spf_tx_st_t ts;
  logic [15:0] t_ty;
  logic [7:0] t_len;
  logic [7:0] t_idx;
  logic [15:0] t_crc;
  logic [15:0] nak_code;
  logic t_bare;
  logic t_nak;
  logic probe_pend;
  logic ping_pend;
  logic [7:0] tx_mem [256];
  logic [3:0] ser_n;
  logic [11:0] ser_cnt;
  logic [9:0] ser_sh;
  logic txd_q;
  logic take_ping;
  logic take_probe;
  logic ld;
  logic [7:0] tx_byte;

  assign take_ping = ts == SPF_T_IDLE && !rsp_send_i && ping_pend;
  assign take_probe = ts == SPF_T_IDLE && !rsp_send_i && !ping_pend && probe_pend;
  assign ld = ts != SPF_T_IDLE && ser_n == 4'h0;

  // Arrival wins over a same-cycle take
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      probe_pend <= 1'b0;
      ping_pend <= 1'b0;
    end else begin
      if (probe_set) probe_pend <= 1'b1;
      else if (take_probe) probe_pend <= 1'b0;
      if (ping_set) ping_pend <= 1'b1;
      else if (take_ping) ping_pend <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rsp_wr_i) tx_mem[rsp_wr_addr_i] <= rsp_wr_data_i;
  end

  always_comb begin
    case (ts)
      SPF_T_TYH: tx_byte = t_ty[15:8];
      SPF_T_TYL: tx_byte = t_ty[7:0];
      SPF_T_LEN: tx_byte = t_len;
      SPF_T_PAY: tx_byte = t_nak ? (t_idx[0] ? nak_code[7:0] : nak_code[15:8]) : tx_mem[t_idx];
      SPF_T_CRCH: tx_byte = t_crc[15:8];
      SPF_T_CRCL: tx_byte = t_crc[7:0];
      default: tx_byte = `SPF_PRE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ts <= SPF_T_IDLE;
      t_ty <= 16'h0000;
      t_len <= 8'h00;
      t_idx <= 8'h00;
      t_crc <= `SPF_CRC_INIT;
      nak_code <= 16'h0000;
      t_bare <= 1'b0;
      t_nak <= 1'b0;
    end else if (ts == SPF_T_IDLE) begin
      t_bare <= 1'b0;
      t_nak <= 1'b0;
      if (rsp_send_i) begin
        t_ty <= rsp_nak_i ? `SPF_T_NAK : rsp_type_i;
        t_len <= rsp_nak_i ? `SPF_NAK_LEN : rsp_len_i;
        t_nak <= rsp_nak_i;
        nak_code <= rsp_type_i;
        ts <= SPF_T_HDR1;
      end else if (take_ping) begin
        t_ty <= `SPF_T_PING;
        t_len <= 8'h00;
        ts <= SPF_T_HDR1;
      end else if (take_probe) begin
        t_ty <= `SPF_T_PING;
        t_bare <= 1'b1;
        ts <= SPF_T_TYH;
      end
    end else if (ld) begin
      case (ts)
        SPF_T_HDR1: ts <= SPF_T_HDR2;
        SPF_T_HDR2: begin
          t_crc <= `SPF_CRC_INIT;
          ts <= SPF_T_TYH;
        end
        SPF_T_TYH: begin
          t_crc <= spf_crc_upd(t_crc, tx_byte);
          ts <= SPF_T_TYL;
        end
        SPF_T_TYL: begin
          t_crc <= spf_crc_upd(t_crc, tx_byte);
          ts <= t_bare ? SPF_T_IDLE : SPF_T_LEN;
        end
        SPF_T_LEN: begin
          t_crc <= spf_crc_upd(t_crc, tx_byte);
          t_idx <= 8'h00;
          ts <= (t_len == 8'h00) ? SPF_T_CRCH : SPF_T_PAY;
        end
        SPF_T_PAY: begin
          t_crc <= spf_crc_upd(t_crc, tx_byte);
          t_idx <= t_idx + 8'h01;
          if (t_idx == t_len - 8'h01) ts <= SPF_T_CRCH;
        end
        SPF_T_CRCH: ts <= SPF_T_CRCL;
        default: ts <= SPF_T_IDLE;
      endcase
    end
  end

  // Serializer: start, 8 data LSB first, stop, then one idle step
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ser_n <= 4'h0;
      ser_cnt <= 12'h000;
      ser_sh <= 10'h3FF;
      txd_q <= 1'b1;
    end else if (ld) begin
      ser_sh <= {1'b1, tx_byte, 1'b0};
      ser_n <= 4'hB;
      ser_cnt <= 12'h000;
    end else if (ser_n != 4'h0) begin
      if (ser_cnt != 12'h000) begin
        ser_cnt <= ser_cnt - 12'h001;
      end else begin
        txd_q <= ser_sh[0];
        ser_sh <= {1'b1, ser_sh[9:1]};
        ser_n <= ser_n - 4'h1;
        ser_cnt <= (ser_n == 4'h1) ? 12'h000 : bit_len - 12'h001;
      end
    end
  end

  assign link.dev_txd = txd_q;

  always_ff @(posedge mclk_i) begin
    if (rst_i) rsp_busy_o <= 1'b0;
    else rsp_busy_o <= ts != SPF_T_IDLE || ser_n != 4'h0 || probe_pend || ping_pend ||
      ping_set || probe_set || rsp_send_i;
  end
endmodule // spf_device
`default_nettype wire

// file: rtl/spf_defines.svh
// Constants of the serial packet framer: framing, check code, timing.
// Assumes a 25 MHz clock on both ends.
`ifndef SPF_DEFINES_SVH
`define SPF_DEFINES_SVH
`define SPF_CLK_HZ 25000000
`define SPF_BAUD0 9600
`define SPF_BAUD1 19200
`define SPF_BAUD2 38400
`define SPF_BAUD3 57600
`define SPF_PRE 8'h55
`define SPF_POLY 16'h1021
`define SPF_CRC_INIT 16'hFFFF
`define SPF_T_PING 16'h504B
`define SPF_T_NAK 16'h1515
`define SPF_NAK_LEN 8'h02
`define SPF_CH_F 8'h46
`define SPF_CH_W 8'h57
`define SPF_CH_S 8'h53
`define SPF_CH_R 8'h52
`define SPF_CH_G 8'h47
`define SPF_CH_P 8'h50
`define SPF_CH_K 8'h4B
`define SPF_LIMIT_S 4
`define SPF_LIMIT_CYC (`SPF_LIMIT_S * `SPF_CLK_HZ)
`define SPF_PROBE_GAP_BITS 30
`endif

// file: rtl/spf_pkg.sv
// Types and helper functions shared by both ends of the framer.
// Needs spf_defines.svh on the include path.
`include "spf_defines.svh"
package spf_pkg;
  typedef enum logic [1:0] {SPF_B9600, SPF_B19200, SPF_B38400, SPF_B57600} spf_baud_t;
  typedef enum logic [2:0] {SPF_CL_OTHER, SPF_CL_WRITE, SPF_CL_SET, SPF_CL_READ,
    SPF_CL_GET} spf_class_t;
  typedef enum logic [2:0] {SPF_R_HDR1, SPF_R_HDR2, SPF_R_TYH, SPF_R_TYL, SPF_R_LEN,
    SPF_R_PAY, SPF_R_CRCH, SPF_R_CRCL} spf_rx_st_t;
  typedef enum logic [3:0] {SPF_T_IDLE, SPF_T_HDR1, SPF_T_HDR2, SPF_T_TYH, SPF_T_TYL,
    SPF_T_LEN, SPF_T_PAY, SPF_T_CRCH, SPF_T_CRCL} spf_tx_st_t;

  function automatic logic [11:0] spf_bit_cycles(spf_baud_t b);
    case (b)
      SPF_B9600: return 12'(`SPF_CLK_HZ / `SPF_BAUD0);
      SPF_B19200: return 12'(`SPF_CLK_HZ / `SPF_BAUD1);
      SPF_B38400: return 12'(`SPF_CLK_HZ / `SPF_BAUD2);
      default: return 12'(`SPF_CLK_HZ / `SPF_BAUD3);
    endcase
  endfunction

  // One byte into the check register, bit 7 first, no final inversion
  function automatic logic [15:0] spf_crc_upd(logic [15:0] c, logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ `SPF_POLY) : (r << 1);
    end
    return r;
  endfunction

  function automatic spf_class_t spf_class_of(logic [15:0] t);
    if (t[7:0] != `SPF_CH_F) return SPF_CL_OTHER;
    case (t[15:8])
      `SPF_CH_W: return SPF_CL_WRITE;
      `SPF_CH_S: return SPF_CL_SET;
      `SPF_CH_R: return SPF_CL_READ;
      `SPF_CH_G: return SPF_CL_GET;
      default: return SPF_CL_OTHER;
    endcase
  endfunction
endpackage

// file: rtl/spf_link_if.sv
// Serial line pair between host and device.
// Each end drives its own transmit line; idle level is high.
`timescale 1ns/1ps
`default_nettype none
interface spf_link_if;
  logic host_txd;
  logic dev_txd;
  modport device (input host_txd, output dev_txd);
  modport host (output host_txd, input dev_txd);
endinterface
`default_nettype wire

// file: rtl/spf_host.sv
// Host end: frames packets or the bare probe, parses device answers.
// Assumes the line is synchronous to mclk_i.
`timescale 1ns/1ps
`default_nettype none
`include "spf_defines.svh"
module spf_host (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire spf_pkg::spf_baud_t baud_sel_i,
  // Serial line
  spf_link_if.host link,
  // Packet to send
  input wire logic wr_i,
  input wire logic [7:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic send_i,
  input wire logic probe_i,
  input wire logic [15:0] send_type_i,
  input wire logic [7:0] send_len_i,
  output logic busy_o,
  // Received answer
  output logic rx_pay_stb_o,
  output logic [7:0] rx_pay_o,
  output logic rx_done_o,
  output logic rx_bad_o,
  output logic [15:0] rx_type_o,
  output logic [7:0] rx_len_o,
  output logic probe_ack_o
);
  import spf_pkg::*;

  logic [11:0] bit_len;
  assign bit_len = spf_bit_cycles(baud_sel_i);

  logic rxd_q;
  logic rx_busy;
  logic [11:0] rx_cnt;
  logic [3:0] rx_idx;
  logic [7:0] rx_sh;
  logic rx_stb;
  logic [7:0] rx_byte;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rxd_q <= 1'b1;
      rx_busy <= 1'b0;
      rx_cnt <= 12'h000;
      rx_idx <= 4'h0;
      rx_sh <= 8'h00;
      rx_stb <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      rx_stb <= 1'b0;
      rxd_q <= link.dev_txd;
      if (!rx_busy) begin
        if (rxd_q && !link.dev_txd) begin
          rx_busy <= 1'b1;
          rx_cnt <= bit_len >> 1;
          rx_idx <= 4'h0;
        end
      end else if (rx_cnt != 12'h000) begin
        rx_cnt <= rx_cnt - 12'h001;
      end else begin
        rx_cnt <= bit_len - 12'h001;
        rx_idx <= rx_idx + 4'h1;
        if (rx_idx == 4'h0) begin
          if (link.dev_txd) rx_busy <= 1'b0;
        end else if (rx_idx < 4'h9) begin
          rx_sh <= {link.dev_txd, rx_sh[7:1]};
        end else begin
          rx_busy <= 1'b0;
          if (link.dev_txd) begin
            rx_stb <= 1'b1;
            rx_byte <= rx_sh;
          end
        end
      end
    end
  end

  spf_rx_st_t rs;
  logic [7:0] idx;
  logic [15:0] crc;
  logic [7:0] crc_hi;
  logic seen_p;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rs <= SPF_R_HDR1;
      idx <= 8'h00;
      crc <= `SPF_CRC_INIT;
      crc_hi <= 8'h00;
      seen_p <= 1'b0;
      rx_pay_stb_o <= 1'b0;
      rx_pay_o <= 8'h00;
      rx_done_o <= 1'b0;
      rx_bad_o <= 1'b0;
      rx_type_o <= 16'h0000;
      rx_len_o <= 8'h00;
      probe_ack_o <= 1'b0;
    end else begin
      rx_pay_stb_o <= 1'b0;
      rx_done_o <= 1'b0;
      rx_bad_o <= 1'b0;
      probe_ack_o <= 1'b0;
      if (rx_stb) begin
        if (rs != SPF_R_TYH && rs != SPF_R_CRCH) crc <= spf_crc_upd(crc, rx_byte);
        case (rs)
          SPF_R_HDR1: begin
            seen_p <= rx_byte == `SPF_CH_P;
            probe_ack_o <= seen_p && rx_byte == `SPF_CH_K;
            if (rx_byte == `SPF_PRE) rs <= SPF_R_HDR2;
          end
          SPF_R_HDR2: rs <= (rx_byte == `SPF_PRE) ? SPF_R_TYH : SPF_R_HDR1;
          SPF_R_TYH: begin
            crc <= spf_crc_upd(`SPF_CRC_INIT, rx_byte);
            rx_type_o[15:8] <= rx_byte;
            rs <= SPF_R_TYL;
          end
          SPF_R_TYL: begin
            rx_type_o[7:0] <= rx_byte;
            rs <= SPF_R_LEN;
          end
          SPF_R_LEN: begin
            rx_len_o <= rx_byte;
            idx <= 8'h00;
            rs <= (rx_byte == 8'h00) ? SPF_R_CRCH : SPF_R_PAY;
          end
          SPF_R_PAY: begin
            rx_pay_stb_o <= 1'b1;
            rx_pay_o <= rx_byte;
            idx <= idx + 8'h01;
            if (idx == rx_len_o - 8'h01) rs <= SPF_R_CRCH;
          end
          SPF_R_CRCH: begin
            crc_hi <= rx_byte;
            rs <= SPF_R_CRCL;
          end
          default: begin
            rs <= SPF_R_HDR1;
            rx_done_o <= {crc_hi, rx_byte} == crc;
            rx_bad_o <= {crc_hi, rx_byte} != crc;
          end
        endcase
      end
    end
  end

  // Packet bytes leave back to back, well inside the completion limit
  spf_tx_st_t ts;
  logic [15:0] t_ty;
  logic [7:0] t_len;
  logic [7:0] t_idx;
  logic [15:0] t_crc;
  logic t_bare;
  logic [7:0] tx_mem [256];
  logic [3:0] ser_n;
  logic [11:0] ser_cnt;
  logic [9:0] ser_sh;
  logic txd_q;
  logic ld;
  logic [7:0] tx_byte;
  assign ld = ts != SPF_T_IDLE && ser_n == 4'h0;

  always_ff @(posedge mclk_i) begin
    if (wr_i) tx_mem[wr_addr_i] <= wr_data_i;
  end

  always_comb begin
    case (ts)
      SPF_T_TYH: tx_byte = t_ty[15:8];
      SPF_T_TYL: tx_byte = t_ty[7:0];
      SPF_T_LEN: tx_byte = t_len;
      SPF_T_PAY: tx_byte = tx_mem[t_idx];
      SPF_T_CRCH: tx_byte = t_crc[15:8];
      SPF_T_CRCL: tx_byte = t_crc[7:0];
      default: tx_byte = `SPF_PRE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ts <= SPF_T_IDLE;
      t_ty <= 16'h0000;
      t_len <= 8'h00;
      t_idx <= 8'h00;
      t_crc <= `SPF_CRC_INIT;
      t_bare <= 1'b0;
    end else if (ts == SPF_T_IDLE) begin
      t_bare <= probe_i && !send_i;
      t_ty <= send_i ? send_type_i : `SPF_T_PING;
      t_len <= send_len_i;
      if (send_i || probe_i) ts <= SPF_T_HDR1;
    end else if (ld) begin
      t_crc <= (ts == SPF_T_TYH) ? spf_crc_upd(`SPF_CRC_INIT, tx_byte)
        : spf_crc_upd(t_crc, tx_byte);
      case (ts)
        SPF_T_HDR1: ts <= SPF_T_HDR2;
        SPF_T_HDR2: ts <= SPF_T_TYH;
        SPF_T_TYH: ts <= SPF_T_TYL;
        SPF_T_TYL: ts <= t_bare ? SPF_T_IDLE : SPF_T_LEN;
        SPF_T_LEN: begin
          t_idx <= 8'h00;
          ts <= (t_len == 8'h00) ? SPF_T_CRCH : SPF_T_PAY;
        end
        SPF_T_PAY: begin
          t_idx <= t_idx + 8'h01;
          if (t_idx == t_len - 8'h01) ts <= SPF_T_CRCH;
        end
        SPF_T_CRCH: begin
          t_crc <= t_crc;
          ts <= SPF_T_CRCL;
        end
        default: ts <= SPF_T_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ser_n <= 4'h0;
      ser_cnt <= 12'h000;
      ser_sh <= 10'h3FF;
      txd_q <= 1'b1;
    end else if (ld) begin
      ser_sh <= {1'b1, tx_byte, 1'b0};
      ser_n <= 4'hB;
      ser_cnt <= 12'h000;
    end else if (ser_n != 4'h0) begin
      if (ser_cnt != 12'h000) begin
        ser_cnt <= ser_cnt - 12'h001;
      end else begin
        txd_q <= ser_sh[0];
        ser_sh <= {1'b1, ser_sh[9:1]};
        ser_n <= ser_n - 4'h1;
        ser_cnt <= (ser_n == 4'h1) ? 12'h000 : bit_len - 12'h001;
      end
    end
  end

  assign link.host_txd = txd_q;

  always_ff @(posedge mclk_i) begin
    if (rst_i) busy_o <= 1'b0;
    else busy_o <= ts != SPF_T_IDLE || ser_n != 4'h0 || send_i || probe_i;
  end
endmodule // spf_host
`default_nettype wire

// file: test/spf_link_checker.sv
// Wire checks for the serial link between host and device ends.
// Assumes 8N1 characters of BIT clocks per bit on both lines.
`timescale 1ns/1ps
`default_nettype none
module spf_frame_track #(
  parameter int BIT = 434
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Watched line
  input wire logic line_i,
  output var int cnt_o,
  output var logic first_o
);
  logic prev;
  // Cycle count inside a character, zero while idle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      prev <= 1'b1;
      cnt_o <= 0;
      first_o <= 1'b1;
    end else begin
      prev <= line_i;
      if (cnt_o == 0 && prev && !line_i) begin
        cnt_o <= 1;
      end else if (cnt_o == 10 * BIT) begin
        cnt_o <= 0;
        first_o <= 1'b0;
      end else if (cnt_o != 0) begin
        cnt_o <= cnt_o + 1;
      end
    end
  end
endmodule // spf_frame_track

module spf_link_checker #(
  parameter int BIT = 434
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Link lines
  input wire logic host_txd,
  input wire logic dev_txd
);
  int hc;
  int dc;
  logic hf;
  logic df;
  spf_frame_track #(.BIT(BIT)) u_host_trk (.mclk_i(mclk_i), .rst_i(rst_i),
    .line_i(host_txd), .cnt_o(hc), .first_o(hf));
  spf_frame_track #(.BIT(BIT)) u_dev_trk (.mclk_i(mclk_i), .rst_i(rst_i),
    .line_i(dev_txd), .cnt_o(dc), .first_o(df));
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_rel;
    !rst_i && $past(rst_i);
  endsequence
  sequence s_hstop;
    host_txd [*8];
  endsequence
  sequence s_dstop;
    dev_txd [*8];
  endsequence
  a_host_rst_idle: assert property (s_rel |-> host_txd)
    else $error("host line low after reset");
  a_dev_rst_idle: assert property (s_rel |-> dev_txd)
    else $error("device line low after reset");
  a_host_start_low: assert property (hc == BIT / 2 |-> !host_txd)
    else $error("host start bit not low");
  a_dev_start_low: assert property (dc == BIT / 2 |-> !dev_txd)
    else $error("device start bit not low");
  a_host_stop_high: assert property (hc == 9 * BIT + BIT / 2 |-> s_hstop)
    else $error("host stop bit not high");
  a_dev_stop_high: assert property (dc == 9 * BIT + BIT / 2 |-> s_dstop)
    else $error("device stop bit not high");
  a_host_hdr_lsb: assert property (hf && hc == BIT + BIT / 2 |-> host_txd)
    else $error("host header bit 0 wrong");
  a_dev_hdr_msb: assert property (df && dc == 8 * BIT + BIT / 2 |-> !dev_txd)
    else $error("device header bit 7 wrong");
endmodule // spf_link_checker
`default_nettype wire

// file: test/serial_packet_framer_crc_tb.sv
// Bench: host and device joined by a link, plus a device fed a bad packet.
// Assumes both ends run at 57600 baud on a 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module serial_packet_framer_crc_tb;
  import spf_pkg::*;
  localparam int BIT = 25000000 / 57600;
  logic mclk_i, rst_i, h_wr, h_send, h_probe, d_wr, d_send, d_nak;
  logic cv_a, cv_b, dc_a, dc_b, pstb, done, bad, ack, rb;
  logic [7:0] h_addr, h_data, h_len, d_paddr, d_addr, d_data, d_len, cl_a, pd_a, rp, rlen;
  logic [15:0] h_type, d_type, ct_a, rtyp;
  spf_baud_t baud;
  spf_class_t cc_a;
  int num_errors, n_checks, n_cv_a, n_cv_b, n_dc_a, n_dc_b, n_done, n_bad, n_ack;
  logic [7:0] rxq[$], q[$], bq[$];
  spf_link_if link();
  spf_link_if link_b();
  spf_device #(.LIMIT_CYC(60000)) u_spf_device (.mclk_i(mclk_i), .rst_i(rst_i),
    .baud_sel_i(baud), .link(link), .cmd_valid_o(cv_a), .cmd_type_o(ct_a), .cmd_len_o(cl_a),
    .cmd_class_o(cc_a), .discard_o(dc_a), .pay_addr_i(d_paddr), .pay_data_o(pd_a),
    .rsp_wr_i(d_wr), .rsp_wr_addr_i(d_addr), .rsp_wr_data_i(d_data), .rsp_send_i(d_send),
    .rsp_nak_i(d_nak), .rsp_type_i(d_type), .rsp_len_i(d_len), .rsp_busy_o(rb));
  spf_device #(.LIMIT_CYC(60000)) u_spf_device_b (.mclk_i(mclk_i), .rst_i(rst_i),
    .baud_sel_i(baud), .link(link_b), .cmd_valid_o(cv_b), .cmd_type_o(), .cmd_len_o(),
    .cmd_class_o(), .discard_o(dc_b), .pay_addr_i(d_paddr), .pay_data_o(),
    .rsp_wr_i(d_wr), .rsp_wr_addr_i(d_addr), .rsp_wr_data_i(d_data), .rsp_send_i(d_send),
    .rsp_nak_i(d_nak), .rsp_type_i(d_type), .rsp_len_i(d_len), .rsp_busy_o());
  spf_host u_spf_host (.mclk_i(mclk_i), .rst_i(rst_i), .baud_sel_i(baud), .link(link),
    .wr_i(h_wr), .wr_addr_i(h_addr), .wr_data_i(h_data), .send_i(h_send), .probe_i(h_probe),
    .send_type_i(h_type), .send_len_i(h_len), .busy_o(), .rx_pay_stb_o(pstb), .rx_pay_o(rp),
    .rx_done_o(done), .rx_bad_o(bad), .rx_type_o(rtyp), .rx_len_o(rlen), .probe_ack_o(ack));
  spf_link_checker #(.BIT(BIT)) u_spf_link_checker (.mclk_i(mclk_i), .rst_i(rst_i),
    .host_txd(link.host_txd), .dev_txd(link.dev_txd));

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    chk_val({8'h00, got}, {8'h00, exp});
  endtask
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    int c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c = c ^ (int'(b[i]) << 8);
      for (int k = 0; k < 8; k++) begin
        c = (((c & 16'h8000) != 0) ? ((c << 1) ^ 16'h1021) : (c << 1)) & 16'hFFFF;
      end
    end
    return 16'(c);
  endfunction
  // Header, body, then check bytes high first
  task automatic frame(input logic [7:0] body[$]);
    logic [15:0] c;
    c = crc16(body);
    q = {8'h55, 8'h55};
    foreach (body[i]) q.push_back(body[i]);
    q.push_back(c[15:8]);
    q.push_back(c[7:0]);
  endtask
  task automatic rx_byte(input logic dev, input logic [7:0] exp);
    logic [7:0] b;
    int k;
    k = 0;
    while ((dev ? link.dev_txd : link.host_txd) !== 1'b0 && k < 20 * BIT) begin
      @(posedge mclk_i);
      k++;
    end
    if (k == 20 * BIT) begin
      num_errors++;
      summarize();
    end
    repeat (BIT / 2) @(posedge mclk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge mclk_i);
      b[i] = dev ? link.dev_txd : link.host_txd;
    end
    repeat (BIT) @(posedge mclk_i);
    chk_byte(b, exp);
  endtask
  task automatic tx_byte(input logic [7:0] b);
    link_b.host_txd <= 1'b0;
    repeat (BIT) @(posedge mclk_i);
    for (int i = 0; i < 8; i++) begin
      link_b.host_txd <= b[i];
      repeat (BIT) @(posedge mclk_i);
    end
    link_b.host_txd <= 1'b1;
    repeat (2 * BIT) @(posedge mclk_i);
  endtask

  always @(posedge mclk_i) begin
    if (cv_a === 1'b1) begin
      n_cv_a++;
      chk_val(ct_a, 16'h5746);
      chk_byte(cl_a, 8'h01);
      chk_val(16'(cc_a), 16'(SPF_CL_WRITE));
    end
    if (cv_b === 1'b1) n_cv_b++;
    if (dc_a === 1'b1) n_dc_a++;
    if (dc_b === 1'b1) n_dc_b++;
    if (pstb === 1'b1) rxq.push_back(rp);
    if (done === 1'b1) begin
      n_done++;
      chk_val(rtyp, 16'h1515);
      chk_byte(rlen, 8'h02);
    end
    if (bad === 1'b1) n_bad++;
    if (ack === 1'b1) n_ack++;
  end
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  initial begin
    logic [7:0] pay;
    logic [15:0] c;
    {rst_i, h_wr, h_send, h_probe, d_wr, d_send, d_nak} = 7'h40;
    {h_addr, h_data, h_len, d_paddr, d_addr, d_data, d_len} = '0;
    {h_type, d_type} = '0;
    baud = SPF_B57600;
    link_b.host_txd = 1'b1;
    pay = 8'($urandom(32'h41AA1949));
    bq = {8'h55, 8'h55, 8'h57, 8'h46, 8'h00};
    c = crc16(bq[2:4]) ^ 16'h0001;
    bq.push_back(c[15:8]);
    bq.push_back(c[7:0]);
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    {h_wr, d_wr, h_data, d_data} <= {2'b11, pay, pay};
    @(posedge mclk_i);
    {h_wr, d_wr, h_send, h_type, h_len} <= {3'b001, 16'h5746, 8'h01};
    @(posedge mclk_i);
    h_send <= 1'b0;
    frame({8'h57, 8'h46, 8'h01, pay});
    fork
      foreach (q[i]) rx_byte(1'b0, q[i]);
      foreach (bq[i]) tx_byte(bq[i]);
    join
    repeat (20) @(posedge mclk_i);
    chk_val(16'(n_cv_a), 16'h0001);
    chk_byte(pd_a, pay);
    chk_val(16'(n_dc_a), 16'h0000);
    chk_val(16'(n_cv_b), 16'h0000);
    chk_val(16'(n_dc_b), 16'h0001);
    {d_nak, d_type, d_len, d_send} <= {1'b1, 16'h5746, 8'h02, 1'b1};
    @(posedge mclk_i);
    d_send <= 1'b0;
    @(posedge mclk_i);
    chk_byte({7'h00, rb}, 8'h01);
    frame({8'h15, 8'h15, 8'h02, 8'h57, 8'h46});
    foreach (q[i]) rx_byte(1'b1, q[i]);
    repeat (20) @(posedge mclk_i);
    chk_val(16'(n_done), 16'h0001);
    chk_val(16'(n_bad), 16'h0000);
    chk_val({rxq[0], rxq[1]}, 16'h5746);
    h_probe <= 1'b1;
    @(posedge mclk_i);
    h_probe <= 1'b0;
    q = {8'h55, 8'h55, 8'h50, 8'h4B};
    foreach (q[i]) rx_byte(1'b0, q[i]);
    repeat (30 * BIT) @(posedge mclk_i);
    rx_byte(1'b1, 8'h50);
    rx_byte(1'b1, 8'h4B);
    repeat (BIT) @(posedge mclk_i);
    chk_val(16'(n_ack), 16'h0001);
    chk_byte({7'h00, rb}, 8'h00);
    summarize();
  end
endmodule // serial_packet_framer_crc_tb
`default_nettype wire
